// ==== src/lps_switch_ctrl.sv ====
`timescale 1ns/1ns
// Summary of operation
// - Dual-feed modes copy network transmit to both customer ports at once.
// - Single unmonitored mode feeds only the selected path's customer port.
// - Framing offers unframed/SF/ESF on T1, five choices on E1.
// - Coding offers B8ZS or AMI on T1, HDB3 or AMI on E1.
// - Automatic mode moves traffic to protection on excess errors or failure.
// - Manual mode changes path only on an operator command.
// - Configurable selection names line one or two as active path.
// - With customer check enabled, customer-caused errors suppress switchover.
// - With customer check disabled, every qualifying error switches.
// - Violation alarm threshold has five choices; exceeding it switches away.
// - Violation clear threshold has five choices; meeting it allows return.
// - Framing alarm threshold has five choices; exceeding it switches away.
// - Framing clear threshold has five choices; meeting it allows return.
// - CRC alarm threshold has five choices; exceeding it switches away.
// - CRC clear threshold has five choices; meeting it allows return.
// - On request, measure and report all three error counts of the selected line over one window.
// - Buzzer on: line alarms sound buzzer and light alarm; silence stops buzzer.
// - Buzzer off: buzzer never sounds.
// - Recovery 00 minutes returns to active path once it is good.
// - Recovery 01 to 98 returns after that many continuous good minutes.
// - Recovery 99 never reverts unless protection itself fails.
// - Report which line currently carries traffic.
// - Silence lights its indicator until the alarm condition goes away.
module lps_switch_ctrl #(
   parameter int WINDOW_CYC = lps_pkg::LPS_WINDOW_CYC,
   parameter int MIN_SEC = lps_pkg::LPS_MIN_SEC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire lps_pkg::lps_cfg_t cfg,
   input wire lps_pkg::lps_line_t line1,
   input wire lps_pkg::lps_line_t line2,
   input wire logic cpeErrorExcess,
   input wire logic manualSwitch,
   input wire logic alarmSilencePress,
   input wire logic measureReq,
   input wire logic netTxData,
   input wire logic netTxValid,
   output logic netTxReady,
   input wire logic cpeTxReady,
   output logic cpeTxValid,
   output logic cpeTx1,
   output logic cpeTx2,
   output logic cpeTx1En,
   output logic cpeTx2En,
   output logic selectedLine2,
   output logic cfgValid,
   output logic alarmLed,
   output logic buzzer,
   output logic alarmSilenceLed,
   output logic cpeFaultLed,
   output logic measValid,
   output lps_pkg::lps_meas_t meas
);
   import lps_pkg::*;

   // ************************************************************
   // Threshold lookup in parts per 1E9, scaled against event count
   // ************************************************************
   function automatic logic [31:0] ppb(input logic [2:0] sel, input logic [1:0] kind);
      logic [31:0] r;
      r = 32'h0;
      unique case (kind)
         2'h0: // Alarm 1E-7,5E-6,1E-5,1E-4,1E-3.
            r = (sel == 3'h0) ? 32'd100 : (sel == 3'h1) ? 32'd5000 :
                (sel == 3'h2) ? 32'd10000 : (sel == 3'h3) ? 32'd100000 : 32'd1000000;
         2'h1: // Clear 1E-9..1E-5.
            r = (sel == 3'h0) ? 32'd1 : (sel == 3'h1) ? 32'd10 :
                (sel == 3'h2) ? 32'd100 : (sel == 3'h3) ? 32'd1000 : 32'd10000;
         2'h2: // Alarm 1E-5..1E-1.
            r = (sel == 3'h0) ? 32'd10000 : (sel == 3'h1) ? 32'd100000 :
                (sel == 3'h2) ? 32'd1000000 : (sel == 3'h3) ? 32'd10000000 : 32'd100000000;
         default: r = 32'h0;
      endcase
      return r;
   endfunction

   // Errors times 1E9 compared to events times threshold, in 64-bit arithmetic.
   function automatic logic over(input logic [31:0] err, input logic [31:0] ev,
                                 input logic [31:0] th, input logic strict);
      logic [63:0] lhs;
      logic [63:0] rhs;
      lhs = 64'(err) * 64'd1000000000;
      rhs = 64'(ev) * 64'(th);
      return strict ? (lhs > rhs) : (lhs >= rhs);
   endfunction

   // ************************************************************
   // Configuration check
   // ************************************************************
   always_comb begin
      if (cfg.isE1) begin
         cfgValid = (cfg.lineFormat <= LPS_FMT_E1_CCSC);
      end else begin
         cfgValid = (cfg.lineFormat <= LPS_FMT_T1_ESF);
      end
   end

   // ************************************************************
   // Error counting over a fixed window
   // ************************************************************
   logic [31:0] winCnt;
   logic winEnd;
   logic [31:0] cnt [2][6];
   logic [31:0] res [2][6];
   logic resValid;

   assign winEnd = (winCnt == 32'(WINDOW_CYC - 1));

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         winCnt <= 32'h0;
      end else if (winEnd) begin
         winCnt <= 32'h0;
      end else begin
         winCnt <= winCnt + 32'h1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int l = 0; l < 2; l++) begin
            for (int k = 0; k < 6; k++) begin
               cnt[l][k] <= 32'h0;
               res[l][k] <= 32'h0;
            end
         end
         resValid <= 1'b0;
      end else begin
         for (int l = 0; l < 2; l++) begin
            lps_line_t s;
            logic [5:0] inc;
            s = (l == 0) ? line1 : line2;
            inc = {s.bitTick, s.lineCodeViolation, s.frameTick, s.framingError,
                   s.crcTick, s.crcError};
            for (int k = 0; k < 6; k++) begin
               if (winEnd) begin
                  res[l][k] <= cnt[l][k] + 32'(inc[5-k]);
                  cnt[l][k] <= 32'h0;
               end else begin
                  cnt[l][k] <= cnt[l][k] + 32'(inc[5-k]);
               end
            end
         end
         if (winEnd) begin
            resValid <= 1'b1;
         end
      end
   end

   // ************************************************************
   // Alarm and clear decisions per line
   // ************************************************************
   logic [1:0] lineBad;
   logic [1:0] lineGood;

   always_comb begin
      for (int l = 0; l < 2; l++) begin
         lps_line_t s;
         logic a;
         logic c;
         s = (l == 0) ? line1 : line2;
         a = over(res[l][1], res[l][0], ppb(cfg.lcvAlarmSel, 2'h0), 1'b1)
           | over(res[l][3], res[l][2], ppb(cfg.frmAlarmSel, 2'h2), 1'b1)
           | over(res[l][5], res[l][4], ppb(cfg.crcAlarmSel, 2'h2), 1'b1);
         c = !over(res[l][1], res[l][0], ppb(cfg.lcvClearSel, 2'h1), 1'b1)
           & !over(res[l][3], res[l][2], ppb(cfg.frmClearSel, 2'h0), 1'b1)
           & !over(res[l][5], res[l][4], ppb(cfg.crcClearSel, 2'h0), 1'b1);
         lineBad[l] = s.lossOfSignal | s.outOfFrame | s.ais | (resValid & a);
         lineGood[l] = !s.lossOfSignal & !s.outOfFrame & !s.ais & resValid & c;
      end
   end

   // ************************************************************
   // Path selection and recovery timer
   // ************************************************************
   logic activeIdx;
   logic onProtection;
   logic activeBad;
   logic protBad;
   logic activeGood;
   logic cpeBlock;
   logic [31:0] secCnt;
   logic [5:0] secInMin;
   logic [6:0] goodMin;
   logic secTick;
   logic minTick;

   assign activeIdx = cfg.activeLine2;
   assign activeBad = lineBad[activeIdx];
   assign protBad = lineBad[!activeIdx];
   assign activeGood = lineGood[activeIdx];
   assign cpeBlock = cfg.cpeCheck & cpeErrorExcess;
   assign secTick = (secCnt == 32'(WINDOW_CYC - 1));
   assign minTick = secTick & (secInMin == 6'(MIN_SEC - 1));

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         secCnt <= 32'h0;
         secInMin <= 6'h0;
         goodMin <= 7'h0;
      end else begin
         secCnt <= secTick ? 32'h0 : secCnt + 32'h1;
         if (!onProtection || !activeGood) begin
            secCnt <= 32'h0;
            secInMin <= 6'h0;
            goodMin <= 7'h0;
         end else if (minTick) begin
            secInMin <= 6'h0;
            if (goodMin != LPS_REC_NEVER) begin
               goodMin <= goodMin + 7'h1;
            end
         end else if (secTick) begin
            secInMin <= secInMin + 6'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         onProtection <= 1'b0;
      end else if (cfg.manualMode) begin
         if (manualSwitch) begin
            onProtection <= !onProtection;
         end
      end else if (!onProtection) begin
         if (activeBad && !protBad && !cpeBlock) begin
            onProtection <= 1'b1;
         end
      end else if (cfg.recoveryMin == LPS_REC_NEVER) begin
         if (protBad && !activeBad) begin
            onProtection <= 1'b0;
         end
      end else if (cfg.recoveryMin == LPS_REC_IMMEDIATE) begin
         if (activeGood) begin
            onProtection <= 1'b0;
         end
      end else if (activeGood && goodMin >= cfg.recoveryMin) begin
         onProtection <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         selectedLine2 <= 1'b0;
         cpeFaultLed <= 1'b0;
      end else begin
         selectedLine2 <= activeIdx ^ onProtection;
         cpeFaultLed <= cpeBlock & activeBad;
      end
   end

   // ************************************************************
   // Transmit path with two-entry buffer
   // ************************************************************
   logic [1:0] bufData;
   logic [1:0] bufCnt;
   logic push;
   logic pop;

   assign netTxReady = (bufCnt != 2'h2);
   assign cpeTxValid = (bufCnt != 2'h0);
   assign push = netTxValid & netTxReady;
   assign pop = cpeTxValid & cpeTxReady;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bufData <= 2'h0;
         bufCnt <= 2'h0;
      end else begin
         if (pop) begin
            bufData[0] <= bufData[1];
         end
         if (push) begin
            if (bufCnt == 2'h0 || (bufCnt == 2'h1 && pop)) begin
               bufData[0] <= netTxData;
            end else begin
               bufData[1] <= netTxData;
            end
         end
         bufCnt <= bufCnt + 2'(push) - 2'(pop);
      end
   end

   always_comb begin
      cpeTx1 = bufData[0];
      cpeTx2 = bufData[0];
      if (cfg.workMode == LPS_SINGLE_UNMON || cfg.workMode == LPS_FRACT) begin
         cpeTx1En = !selectedLine2;
         cpeTx2En = selectedLine2;
      end else begin
         cpeTx1En = 1'b1;
         cpeTx2En = 1'b1;
      end
   end

   // ************************************************************
   // Alarms, buzzer and silence
   // ************************************************************
   logic alarmCond;
   logic silenced;

   assign alarmCond = line1.lossOfSignal | line1.outOfFrame | line1.ais | line1.rai
                    | line2.lossOfSignal | line2.outOfFrame | line2.ais | line2.rai;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         silenced <= 1'b0;
      end else if (!alarmCond) begin
         silenced <= 1'b0;
      end else if (alarmSilencePress) begin
         silenced <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         alarmLed <= 1'b0;
         buzzer <= 1'b0;
         alarmSilenceLed <= 1'b0;
      end else begin
         alarmLed <= alarmCond & cfg.buzzerEnable;
         buzzer <= alarmCond & cfg.buzzerEnable & !silenced
                   & !(alarmSilencePress & alarmCond);
         alarmSilenceLed <= (silenced | alarmSilencePress) & alarmCond;
      end
   end

   // ************************************************************
   // Measurement report on request
   // ************************************************************
   logic measPending;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         measPending <= 1'b0;
         measValid <= 1'b0;
         meas <= '0;
      end else begin
         measValid <= 1'b0;
         if (measureReq) begin
            measPending <= 1'b1;
         end
         if ((measPending || measureReq) && winEnd) begin
            measPending <= 1'b0;
            measValid <= 1'b1;
            meas.line_code_violation <= cnt[selectedLine2][1] + 32'(selectedLine2 ? line2.lineCodeViolation
                                                                  : line1.lineCodeViolation);
            meas.frm <= cnt[selectedLine2][3] + 32'(selectedLine2 ? line2.framingError
                                                                  : line1.framingError);
            meas.crc <= cnt[selectedLine2][5] + 32'(selectedLine2 ? line2.crcError
                                                                  : line1.crcError);
         end
      end
   end

endmodule

// ==== src/lps_pkg.sv ====
package lps_pkg;

   // ************************************************************
   // Modes and encodings
   // ************************************************************
   typedef enum logic [1:0] {
      LPS_DUAL_MON = 2'h0,
      LPS_FRACT = 2'h1,
      LPS_DUAL_UNMON = 2'h2,
      LPS_SINGLE_UNMON = 2'h3
   } lps_work_t;

   localparam logic [2:0] LPS_FMT_UNFRAMED = 3'h0;
   localparam logic [2:0] LPS_FMT_T1_SF = 3'h1;
   localparam logic [2:0] LPS_FMT_T1_ESF = 3'h2;
   localparam logic [2:0] LPS_FMT_E1_CAS = 3'h1;
   localparam logic [2:0] LPS_FMT_E1_CCS = 3'h2;
   localparam logic [2:0] LPS_FMT_E1_CASC = 3'h3;
   localparam logic [2:0] LPS_FMT_E1_CCSC = 3'h4;
   localparam logic LPS_CODE_AMI = 1'h0;
   localparam logic LPS_CODE_ZS = 1'h1;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int LPS_CLK_HZ = 10000000;
   localparam int LPS_WINDOW_MS = 1000;
   localparam int LPS_WINDOW_CYC = LPS_CLK_HZ / 1000 * LPS_WINDOW_MS;
   localparam int LPS_MIN_SEC = 60;
   localparam logic [6:0] LPS_REC_IMMEDIATE = 7'h00;
   localparam logic [6:0] LPS_REC_NEVER = 7'h63;
   localparam int LPS_RATIO_W = 32;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic isE1;
      lps_work_t workMode;
      logic manualMode;
      logic activeLine2;
      logic cpeCheck;
      logic buzzerEnable;
      logic [6:0] recoveryMin;
      logic [2:0] lcvAlarmSel;
      logic [2:0] lcvClearSel;
      logic [2:0] frmAlarmSel;
      logic [2:0] frmClearSel;
      logic [2:0] crcAlarmSel;
      logic [2:0] crcClearSel;
      logic [2:0] lineFormat;
      logic lineCode;
   } lps_cfg_t;

   typedef struct packed {
      logic bitTick;
      logic lineCodeViolation;
      logic frameTick;
      logic framingError;
      logic crcTick;
      logic crcError;
      logic lossOfSignal;
      logic outOfFrame;
      logic ais;
      logic rai;
   } lps_line_t;

   typedef struct packed {
      logic [LPS_RATIO_W-1:0] line_code_violation;
      logic [LPS_RATIO_W-1:0] crc;
      logic [LPS_RATIO_W-1:0] frm;
   } lps_meas_t;

endpackage

// ==== bench/lps_switch_ctrl_assertions.sv ====
`timescale 1ns/1ns
// ************************************************************
// Port checker
// ************************************************************
module lps_chk #(
   parameter int WINDOW_CYC = 100
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire lps_pkg::lps_cfg_t cfg,
   input wire lps_pkg::lps_line_t line1,
   input wire lps_pkg::lps_line_t line2,
   input wire logic manualSwitch,
   input wire logic measureReq,
   input wire logic netTxValid,
   input wire logic netTxReady,
   input wire logic cpeTxReady,
   input wire logic cpeTxValid,
   input wire logic cpeTx1,
   input wire logic cpeTx1En,
   input wire logic cpeTx2En,
   input wire logic selectedLine2,
   input wire logic cfgValid,
   input wire logic buzzer,
   input wire logic alarmSilenceLed,
   input wire logic measValid
);
   import lps_pkg::*;
   localparam int MEAS_MAX = WINDOW_CYC + 1;
   logic dual;
   logic anyAlarm;
   logic bad2;
   assign dual = cfg.workMode inside {LPS_DUAL_MON, LPS_DUAL_UNMON};
   assign bad2 = line2.lossOfSignal | line2.outOfFrame | line2.ais | line2.rai;
   assign anyAlarm = bad2 | line1.lossOfSignal | line1.outOfFrame | line1.ais | line1.rai;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   a_dual_feed_both:
      assert property (dual |-> cpeTx1En && cpeTx2En) else $error("dual feed port idle");
   a_single_feed_one:
      assert property (cfg.workMode == LPS_SINGLE_UNMON |-> cpeTx1En != cpeTx2En
         && cpeTx2En == selectedLine2) else $error("single feed wrong port");
   a_format_legal:
      assert property (cfgValid == (cfg.isE1 ? cfg.lineFormat <= LPS_FMT_E1_CCSC
         : cfg.lineFormat <= LPS_FMT_T1_ESF)) else $error("format check wrong");
   a_reset_select:
      assert property ($past(reset_n) && !$past(reset_n, 2) |-> selectedLine2 == cfg.activeLine2)
         else $error("active path not taken");
   a_manual_still:
      assert property (cfg.manualMode && $past(cfg.manualMode, 2) && $past(reset_n, 2)
         && $changed(selectedLine2) |-> $past(manualSwitch) || $past(manualSwitch, 2))
         else $error("manual path moved alone");
   a_manual_toggle:
      assert property (cfg.manualMode && manualSwitch |-> ##2 selectedLine2 !=
         $past(selectedLine2, 2)) else $error("manual command ignored");
   a_los_switch:
      assert property (!cfg.manualMode && !selectedLine2 && line1.lossOfSignal && !bad2
         |-> ##[1:3] selectedLine2) else $error("no switch on signal loss");
   a_buzzer_off:
      assert property (!cfg.buzzerEnable ##1 !cfg.buzzerEnable |-> !buzzer)
         else $error("buzzer while disabled");
   a_silence_quiet:
      assert property (alarmSilenceLed |-> !buzzer) else $error("buzzer while silenced");
   a_silence_clear:
      assert property (!anyAlarm [*3] |-> !alarmSilenceLed) else $error("silence lamp stuck");
   a_meas_answer:
      assert property (measureReq |-> ##[1:MEAS_MAX] measValid) else $error("no report");
   a_meas_pulse:
      assert property (measValid |=> !measValid) else $error("report pulse too long");
   a_stall_hold:
      assert property (cpeTxValid && !cpeTxReady |=> cpeTxValid && $stable(cpeTx1))
         else $error("stalled word lost");
   c_manual: cover property (cfg.manualMode && manualSwitch);
   c_report: cover property (measValid);
   c_silence: cover property ($rose(alarmSilenceLed));
   c_full: cover property (netTxValid && !netTxReady);
endmodule
bind lps_switch_ctrl lps_chk #(.WINDOW_CYC(WINDOW_CYC)) u_chk (.clk(clk), .reset_n(reset_n),
   .cfg(cfg), .line1(line1), .line2(line2), .manualSwitch(manualSwitch),
   .measureReq(measureReq), .netTxValid(netTxValid), .netTxReady(netTxReady),
   .cpeTxReady(cpeTxReady), .cpeTxValid(cpeTxValid), .cpeTx1(cpeTx1), .cpeTx1En(cpeTx1En),
   .cpeTx2En(cpeTx2En), .selectedLine2(selectedLine2), .cfgValid(cfgValid), .buzzer(buzzer),
   .alarmSilenceLed(alarmSilenceLed), .measValid(measValid));

// ==== bench/lps_line_model.sv ====
`timescale 1ns/1ns
// ************************************************************
// Network line model: one bit, frame and block each cycle
// ************************************************************
module lps_line_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] errEvery,
   input wire logic [2:0] errKind,
   input wire logic [3:0] alarmBits,
   output lps_pkg::lps_line_t line
);
   import lps_pkg::*;
   logic [7:0] phase;
   logic errNow;
   // Errors repeat with an exact period so a window holds a known count.
   assign errNow = (errEvery != 8'h00) && (phase == 8'h00);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase <= 8'h00;
      end else if (phase + 8'h01 >= errEvery) begin
         phase <= 8'h00;
      end else begin
         phase <= phase + 8'h01;
      end
   end
   always_comb begin
      line.bitTick = reset_n;
      line.frameTick = reset_n;
      line.crcTick = reset_n;
      line.lineCodeViolation = errNow & errKind[0];
      line.framingError = errNow & errKind[1];
      line.crcError = errNow & errKind[2];
      {line.lossOfSignal, line.outOfFrame, line.ais, line.rai} = alarmBits;
   end
endmodule

// ==== bench/lps_switch_ctrl_tb.sv ====
`timescale 1ns/1ns
// ************************************************************
// Protection switch bench
// ************************************************************
module lps_switch_ctrl_tb;
   import lps_pkg::*;
   localparam int WIN = 100;
   logic clk, reset_n, cpeErrorExcess, manualSwitch, alarmSilencePress, measureReq;
   logic netTxData, netTxValid, cpeTxReady, streamOn, netTxReady, cpeTxValid, cpeTx1, cpeTx2;
   logic cpeTx1En, cpeTx2En, selectedLine2, cfgValid, alarmLed, buzzer, alarmSilenceLed;
   logic cpeFaultLed, measValid;
   lps_meas_t meas;
   lps_cfg_t cfg;
   lps_line_t line1, line2;
   logic [7:0] err1;
   logic [2:0] kind1;
   logic [3:0] alm1, alm2;
   int badCount, nChecks, cycles, accepted, a0;
   logic txq[$];
   lps_switch_ctrl #(.WINDOW_CYC(WIN), .MIN_SEC(2)) DUT (.clk(clk), .reset_n(reset_n),
      .cfg(cfg), .line1(line1), .line2(line2), .cpeErrorExcess(cpeErrorExcess),
      .manualSwitch(manualSwitch), .alarmSilencePress(alarmSilencePress),
      .measureReq(measureReq), .netTxData(netTxData), .netTxValid(netTxValid),
      .netTxReady(netTxReady), .cpeTxReady(cpeTxReady), .cpeTxValid(cpeTxValid),
      .cpeTx1(cpeTx1), .cpeTx2(cpeTx2), .cpeTx1En(cpeTx1En), .cpeTx2En(cpeTx2En),
      .selectedLine2(selectedLine2), .cfgValid(cfgValid), .alarmLed(alarmLed),
      .buzzer(buzzer), .alarmSilenceLed(alarmSilenceLed), .cpeFaultLed(cpeFaultLed),
      .measValid(measValid), .meas(meas));
   lps_line_model u_net1 (.clk(clk), .reset_n(reset_n), .errEvery(err1), .errKind(kind1),
      .alarmBits(alm1), .line(line1));
   lps_line_model u_net2 (.clk(clk), .reset_n(reset_n), .errEvery(8'h00), .errKind(3'h0),
      .alarmBits(alm2), .line(line2));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic testDone();
      $display("checks %0d mismatches %0d", nChecks, badCount);
      if (badCount == 0 && nChecks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp) begin
         badCount++;
         $display("mismatch t=%0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      check_val({31'h0, got}, {31'h0, exp});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wait_sel(input logic exp, input int maxc);
      int n;
      n = 0;
      @(negedge clk);
      while (selectedLine2 !== exp && n < maxc) begin
         @(negedge clk);
         n++;
      end
      check_bit(selectedLine2, exp);
      @(posedge clk);
   endtask
   task automatic set_l1(input logic [7:0] e, input logic [2:0] k, input logic [3:0] a);
      @(posedge clk);
      err1 <= e;
      kind1 <= k;
      alm1 <= a;
   endtask
   task automatic pulse(input int which);
      @(posedge clk);
      {measureReq, alarmSilencePress, manualSwitch} <= 3'h1 << which;
      @(posedge clk);
      {measureReq, alarmSilencePress, manualSwitch} <= 3'h0;
   endtask
   task automatic rand_thresh();
      @(posedge clk);
      {cfg.lcvAlarmSel, cfg.lcvClearSel, cfg.frmAlarmSel} <= {3'($urandom_range(4)),
         3'($urandom_range(4)), 3'($urandom_range(4))};
      {cfg.frmClearSel, cfg.crcAlarmSel, cfg.crcClearSel} <= {3'($urandom_range(4)),
         3'($urandom_range(4)), 3'($urandom_range(4))};
   endtask
   function automatic logic [31:0] exp_count(input int period, input logic on);
      return on ? 32'(WIN / period) : 32'h0;
   endfunction
   // Scoreboard of the transmit stream, plus random traffic once enabled.
   always @(posedge clk) begin
      cycles++;
      if (!reset_n) begin
         txq.delete();
      end
      if (reset_n && netTxValid && netTxReady) begin
         txq.push_back(netTxData);
         accepted++;
         netTxData <= 1'($urandom);
      end
      if (cpeTxValid && cpeTxReady) begin
         check_bit(cpeTx1, txq[0]);
         if (cfg.workMode inside {LPS_DUAL_MON, LPS_DUAL_UNMON}) begin
            check_bit(cpeTx2, txq[0]);
         end
         void'(txq.pop_front());
      end
      if (streamOn) begin
         if (!netTxValid || netTxReady) begin
            netTxValid <= 1'($urandom);
         end
         cpeTxReady <= 1'($urandom);
      end
      if (cycles == 40000) begin
         badCount++;
         testDone();
      end
   end
   initial begin
      void'($urandom(32'h9655798D));
      {reset_n, cpeErrorExcess, manualSwitch, alarmSilencePress, measureReq} = 5'h00;
      {netTxData, netTxValid, cpeTxReady, streamOn, err1, kind1, alm1, alm2} = '0;
      {badCount, nChecks, cycles, accepted} = '0;
      cfg = '0;
      cfg.buzzerEnable = 1'b1;
      cfg.lineFormat = LPS_FMT_T1_ESF;
      tick(10);
      reset_n <= 1'b1;
      for (int f = 0; f < 16; f++) begin
         @(posedge clk);
         {cfg.isE1, cfg.lineFormat} <= 4'(f);
         cfg.lineCode <= 1'($urandom);
         @(negedge clk);
         check_bit(cfgValid, f[2:0] <= (f[3] ? 3'h4 : 3'h2));
      end
      for (int m = 0; m < 4; m++) begin
         @(posedge clk);
         {cfg.workMode, cpeTxReady, netTxValid} <= {2'(m), 2'h1};
         a0 = accepted;
         tick(6);
         netTxValid <= 1'b0;
         check_val(32'(accepted - a0), 32'h2);
         cpeTxReady <= 1'b1;
         tick(4);
         check_bit(cpeTxValid, 1'b0);
      end
      {cfg.workMode, cfg.isE1, cfg.lineFormat} <= {LPS_DUAL_MON, 1'b0, LPS_FMT_T1_ESF};
      streamOn <= 1'b1;
      cpeErrorExcess <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         rand_thresh();
         set_l1(k < 3 ? 8'h02 : 8'h00, 3'(1 << k), k < 3 ? 4'h0 : 4'h8);
         wait_sel(1'b1, 4 * WIN);
         set_l1(8'h00, 3'h0, 4'h0);
         wait_sel(1'b0, 4 * WIN);
      end
      @(posedge clk);
      cfg.cpeCheck <= 1'b1;
      set_l1(8'h02, 3'h1, 4'h0);
      tick(4 * WIN);
      check_val(32'({selectedLine2, cpeFaultLed}), 32'h1);
      set_l1(8'h00, 3'h0, 4'h0);
      {cfg.cpeCheck, cfg.recoveryMin, cfg.workMode} <= {1'b0, 7'h01, LPS_SINGLE_UNMON};
      tick(3 * WIN);
      set_l1(8'h02, 3'h1, 4'h0);
      wait_sel(1'b1, 4 * WIN);
      set_l1(8'h00, 3'h0, 4'h0);
      tick(150);
      check_bit(selectedLine2, 1'b1);
      set_l1(8'h02, 3'h1, 4'h0);
      tick(WIN);
      set_l1(8'h00, 3'h0, 4'h0);
      tick(150);
      check_bit(selectedLine2, 1'b1);
      wait_sel(1'b0, 6 * WIN);
      cfg.recoveryMin <= LPS_REC_NEVER;
      set_l1(8'h02, 3'h1, 4'h0);
      wait_sel(1'b1, 4 * WIN);
      set_l1(8'h00, 3'h0, 4'h0);
      tick(5 * WIN);
      check_bit(selectedLine2, 1'b1);
      alm2 <= 4'h8;
      wait_sel(1'b0, 10);
      alm2 <= 4'h0;
      {cfg.recoveryMin, cfg.manualMode, cfg.workMode} <= {7'h00, 1'b1, LPS_DUAL_UNMON};
      tick(3 * WIN);
      set_l1(8'h02, 3'h1, 4'h8);
      tick(3 * WIN);
      check_bit(selectedLine2, 1'b0);
      set_l1(8'h00, 3'h0, 4'h0);
      pulse(0);
      wait_sel(1'b1, 5);
      pulse(0);
      wait_sel(1'b0, 5);
      for (int a = 0; a < 4; a++) begin
         set_l1(8'h00, 3'h0, 4'(1 << a));
         tick(4);
         check_bit(buzzer & alarmLed, 1'b1);
         pulse(1);
         tick(3);
         check_bit(buzzer, 1'b0);
         check_bit(alarmSilenceLed & alarmLed, 1'b1);
         set_l1(8'h00, 3'h0, 4'h0);
         tick(4);
         check_bit(alarmSilenceLed, 1'b0);
      end
      cfg.buzzerEnable <= 1'b0;
      set_l1(8'h00, 3'h0, 4'h8);
      tick(5);
      check_bit(buzzer, 1'b0);
      for (int p = 0; p < 2; p++) begin
         set_l1(p ? 8'h05 : 8'h04, p ? 3'h1 : 3'h7, 4'h0);
         tick(WIN + 10);
         pulse(2);
         wait (measValid === 1'b1);
         @(negedge clk);
         check_val(meas.line_code_violation, exp_count(p ? 5 : 4, 1'b1));
         check_val(meas.crc, exp_count(4, !p));
         check_val(meas.frm, exp_count(4, !p));
      end
      set_l1(8'h00, 3'h0, 4'h0);
      {cfg.manualMode, cfg.activeLine2} <= 2'h1;
      tick(2 * WIN);
      reset_n <= 1'b0;
      tick(3);
      reset_n <= 1'b1;
      tick(3);
      check_bit(selectedLine2, 1'b1);
      alm2 <= 4'h8;
      wait_sel(1'b0, 10);
      testDone();
   end
endmodule
